// *** rtl/gpio_pkg.sv ***
// package: register map, fields and sense encodings of the gpio port
package gpio_pkg;
  localparam int          PIN_COUNT       = 8;
  localparam logic [5:0]  OFS_DRIVE_EN    = 6'h00;
  localparam logic [5:0]  OFS_DIR_SET     = 6'h01;
  localparam logic [5:0]  OFS_DIR_CLR     = 6'h02;
  localparam logic [5:0]  OFS_DIR_FLIP    = 6'h03;
  localparam logic [5:0]  OFS_LEVEL       = 6'h04;
  localparam logic [5:0]  OFS_LVL_SET     = 6'h05;
  localparam logic [5:0]  OFS_LVL_CLR     = 6'h06;
  localparam logic [5:0]  OFS_LVL_FLIP    = 6'h07;
  localparam logic [5:0]  OFS_PIN_IN      = 6'h08;
  localparam logic [5:0]  OFS_FLAGS       = 6'h09;
  localparam logic [5:0]  OFS_PIN_CFG     = 6'h10;
  // alias bank: drive enable, level, input, flags
  localparam logic [5:0]  OFS_ALIAS_BASE  = 6'h20;
  localparam logic [5:0]  OFS_ALIAS_DIR   = 6'h20;
  localparam logic [5:0]  OFS_ALIAS_LVL   = 6'h21;
  localparam logic [5:0]  OFS_ALIAS_IN    = 6'h22;
  localparam logic [5:0]  OFS_ALIAS_FLAGS = 6'h23;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam int          CFG_FLIP_BIT    = 7;
  localparam int          CFG_PULL_BIT    = 3;
  localparam int          CFG_SENSE_LSB   = 0;
  localparam logic [7:0]  CFG_WRITE_MASK  = 8'h8f;
  localparam logic [7:0]  IRQ_VECTOR_OFS  = 8'h00;
  localparam int          DEAD_CYCLES     = 3;

  typedef enum logic [2:0] {
    SENSE_NONE  = 3'h0,
    SENSE_BOTH  = 3'h1,
    SENSE_RISE  = 3'h2,
    SENSE_FALL  = 3'h3,
    SENSE_OFF   = 3'h4,
    SENSE_LOW   = 3'h5
  } sense_e;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_s;

  typedef struct packed {
    logic [7:0] in;
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pad_s;
endpackage : gpio_pkg

// *** rtl/gpio_port.sv ***
// gpio port: direction, level, input sync, per pin config, sensing, flags
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

// Overview of operation
// - after reset all pads are inputs with drivers off and input buffers on
// - input value register is fed through a two stage synchroniser
// - synchroniser of a pin with input-off sense is held, not clocked
// - pin level is readable whether the pin is input or output
// - config register of pin n sits at offset 0x10 plus n
// - drive-enable bit one makes pin an output, zero an input
// - drive-enable set strobe sets only the ones written
// - drive-enable clear strobe clears only the ones written
// - drive-enable flip strobe inverts the ones written
// - level set and clear strobes set or clear written ones only
// - writing ones to level flip or input register inverts level bits
// - input bit reflects pin only while sense is not input-off
// - alias bank mirrors direction, level, input and flags exactly
// - polarity flip inverts the output path and the sensed input, not the input value register
// - changing polarity flip makes an edge seen by sensing
// - pull resistor bit one enables the pullup
// - sense select picks none, both, rise, fall, low or input-off
// - partly async pins wake only for both-edge or low level
// - async sensing wakes the device even with no clock running
// - sense condition sets the pin's flag bit
// - interrupt request is high while an enabled pin has its flag set
// - all pins share one vector at offset 0x00
// - partly async pins raise no new interrupt for three cycles
// - level bit drives the pin only while direction is output
// - port runs on main clock, sync stops when it stops
module gpio_port
  import gpio_pkg::*;
#(
  parameter int                   PINS       = gpio_pkg::PIN_COUNT,
  parameter logic [PINS-1:0]      ASYNC_PINS = 8'h04
)(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               resetn,
  // register port
  input  wire gpio_pkg::bus_req_s bus_req,
  output logic [7:0]              rdata,
  // pads
  input  wire logic [PINS-1:0]    pad_in,
  output logic [PINS-1:0]         pad_out,
  output logic [PINS-1:0]         pad_oe,
  output logic [PINS-1:0]         pad_pull,
  output logic [PINS-1:0]         pad_in_en,
  // interrupt and wake
  output logic                    irq,
  output logic [7:0]              irq_vector,
  output logic                    wake
);
  import gpio_pkg::*;

  logic [PINS-1:0] drive_en;
  logic [PINS-1:0] level;
  logic [PINS-1:0] pin_event_flags;
  logic [7:0]      per_pin_config [PINS];
  logic [PINS-1:0] sync1;
  logic [PINS-1:0] sync2;
  logic [PINS-1:0] sensed_prev;
  logic [PINS-1:0] rdata_valid_unused;
  logic [1:0]      dead_cnt [PINS];
  logic [7:0]      rdata_q;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = bus_req.wr && (a == ofs);
  endfunction : hit

  wire [5:0] a = bus_req.addr;
  wire [7:0] wd = bus_req.wdata;

  // register decode, alias bank folded onto the regular offsets
  wire wr_dir      = hit(a, OFS_DRIVE_EN) || hit(a, OFS_ALIAS_DIR);
  wire wr_dir_set  = hit(a, OFS_DIR_SET);
  wire wr_dir_clr  = hit(a, OFS_DIR_CLR);
  wire wr_dir_flip = hit(a, OFS_DIR_FLIP);
  wire wr_lvl      = hit(a, OFS_LEVEL) || hit(a, OFS_ALIAS_LVL);
  wire wr_lvl_set  = hit(a, OFS_LVL_SET);
  wire wr_lvl_clr  = hit(a, OFS_LVL_CLR);
  wire wr_lvl_flip = hit(a, OFS_LVL_FLIP) || hit(a, OFS_PIN_IN)
                     || hit(a, OFS_ALIAS_IN);
  wire wr_flags    = hit(a, OFS_FLAGS) || hit(a, OFS_ALIAS_FLAGS);
  wire cfg_sel     = bus_req.wr && (a >= OFS_PIN_CFG) && (a < OFS_PIN_CFG + 6'(PINS));
  wire [5:0] cfg_idx = a - OFS_PIN_CFG;

  wire [PINS-1:0] wd_p = wd[PINS-1:0];

  wire [PINS-1:0] next_drive_en =
      wr_dir      ? wd_p :
      wr_dir_set  ? (drive_en | wd_p) :
      wr_dir_clr  ? (drive_en & ~wd_p) :
      wr_dir_flip ? (drive_en ^ wd_p) : drive_en;

  wire [PINS-1:0] next_level =
      wr_lvl      ? wd_p :
      wr_lvl_set  ? (level | wd_p) :
      wr_lvl_clr  ? (level & ~wd_p) :
      wr_lvl_flip ? (level ^ wd_p) : level;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      drive_en <= '0;
      level    <= '0;
    end
    else
    begin
      drive_en <= next_drive_en;
      level    <= next_level;
    end
  end

  // per pin logic
  logic [PINS-1:0] flip;
  logic [PINS-1:0] in_off;
  logic [PINS-1:0] cond;
  logic [PINS-1:0] enabled;
  logic [PINS-1:0] wake_ok;
  logic [PINS-1:0] next_flags;

  genvar n;
  generate
    for (n = 0; n < PINS; n++)
    begin : g_pin
      wire [2:0] sense     = per_pin_config[n][CFG_SENSE_LSB +: 3];
      assign flip[n]       = per_pin_config[n][CFG_FLIP_BIT];
      assign in_off[n]     = (sense == SENSE_OFF);
      assign enabled[n]    = (sense == SENSE_BOTH) || (sense == SENSE_RISE)
                             || (sense == SENSE_FALL) || (sense == SENSE_LOW);
      assign pad_out[n]    = level[n] ^ flip[n];
      assign pad_oe[n]     = drive_en[n];
      assign pad_pull[n]   = per_pin_config[n][CFG_PULL_BIT];
      assign pad_in_en[n]  = ~in_off[n];

      // sensed value includes polarity, so a flip change is an edge
      wire sensed = sync2[n] ^ flip[n];
      wire rise   = sensed & ~sensed_prev[n];
      wire fall   = ~sensed & sensed_prev[n];
      wire dead   = !ASYNC_PINS[n] && (dead_cnt[n] != 2'h0);
      always_comb
      begin
        case (sense)
          SENSE_BOTH: cond[n] = rise | fall;
          SENSE_RISE: cond[n] = rise;
          SENSE_FALL: cond[n] = fall;
          SENSE_LOW:  cond[n] = ~sensed;
          default:    cond[n] = 1'b0;
        endcase
      end
      wire fire = cond[n] && !dead;
      // set wins over a clear in the same cycle
      assign next_flags[n] = fire || (pin_event_flags[n] && !(wr_flags && wd[n]));

      // wake is combinational on the raw pad so it works with no clock
      wire raw = pad_in[n] ^ flip[n];
      assign wake_ok[n] = ASYNC_PINS[n] ? enabled[n]
                          : ((sense == SENSE_BOTH) || (sense == SENSE_LOW));
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          per_pin_config[n] <= RESET_BYTE;
          sync1[n]          <= 1'b0;
          sync2[n]          <= 1'b0;
          sensed_prev[n]    <= 1'b0;
          dead_cnt[n]       <= 2'h0;
        end
        else
        begin
          if (cfg_sel && cfg_idx == 6'(n))
            per_pin_config[n] <= wd & CFG_WRITE_MASK;
          if (!in_off[n])
          begin
            sync1[n] <= pad_in[n];
            sync2[n] <= sync1[n];
          end
          sensed_prev[n] <= sensed;
          if (fire)
            dead_cnt[n] <= 2'(DEAD_CYCLES);
          else if (dead_cnt[n] != 2'h0)
            dead_cnt[n] <= dead_cnt[n] - 2'h1;
        end
      end
      assign rdata_valid_unused[n] = raw;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pin_event_flags <= '0;
    else
      pin_event_flags <= next_flags;
  end

  // input value: raw synchronised level, zero while input is off
  wire [PINS-1:0] pin_in_value = sync2 & ~in_off;

  // async wake on raw pad: edge/level condition on enabled pin, only both or low on partly async pins
  assign wake = |(wake_ok & (rdata_valid_unused ^ sync2 | ~rdata_valid_unused)
                 & (ASYNC_PINS | ~in_off)) && |enabled;

  assign irq        = |(pin_event_flags & enabled);
  assign irq_vector = IRQ_VECTOR_OFS;

  // read mux
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    if (a == OFS_DRIVE_EN || a == OFS_DIR_SET || a == OFS_DIR_CLR
        || a == OFS_DIR_FLIP || a == OFS_ALIAS_DIR)
      next_rdata = 8'(drive_en);
    else if (a == OFS_LEVEL || a == OFS_LVL_SET || a == OFS_LVL_CLR
             || a == OFS_LVL_FLIP || a == OFS_ALIAS_LVL)
      next_rdata = 8'(level);
    else if (a == OFS_PIN_IN || a == OFS_ALIAS_IN)
      next_rdata = 8'(pin_in_value);
    else if (a == OFS_FLAGS || a == OFS_ALIAS_FLAGS)
      next_rdata = 8'(pin_event_flags);
    else if (a >= OFS_PIN_CFG && a < OFS_PIN_CFG + 6'(PINS))
      next_rdata = per_pin_config[cfg_idx[2:0]];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      rdata_q <= 8'h00;
    else
      rdata_q <= bus_req.rd ? next_rdata : 8'h00;
  end
  assign rdata = rdata_q;

  // assertions
  a_dir_set_only: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_dir_set |=> drive_en == ($past(drive_en) | $past(wd_p)))
    else $error("drive enable set strobe wrong");
  a_dir_clr_only: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_dir_clr |=> drive_en == ($past(drive_en) & ~$past(wd_p)))
    else $error("drive enable clear strobe wrong");
  a_dir_flip_bits: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_dir_flip |=> drive_en == ($past(drive_en) ^ $past(wd_p)))
    else $error("drive enable flip strobe wrong");
  a_in_write_flips: assert property (@(posedge core_clk) disable iff (!resetn)
    hit(a, OFS_PIN_IN) |=> level == ($past(level) ^ $past(wd_p)))
    else $error("input write did not flip level");
  a_irq_follows_flag: assert property (@(posedge core_clk) disable iff (!resetn)
    irq == |(pin_event_flags & enabled))
    else $error("interrupt request mismatch");
  a_flag_clear_write: assert property (@(posedge core_clk) disable iff (!resetn)
    (wr_flags && wd[0] && !cond[0]) |=> !pin_event_flags[0])
    else $error("flag not cleared by write");
  sequence s_fire0;
    cond[0] && !ASYNC_PINS[0] && dead_cnt[0] == 2'h0;
  endsequence
  a_dead_time_gap: assert property (@(posedge core_clk) disable iff (!resetn)
    s_fire0 |=> dead_cnt[0] == 2'h3 ##1 dead_cnt[0] == 2'h2)
    else $error("dead time count wrong");
  a_input_off_zero: assert property (@(posedge core_clk) disable iff (!resetn)
    in_off[1] |-> !pin_in_value[1])
    else $error("input visible while off");
  a_read_next_cycle: assert property (@(posedge core_clk) disable iff (!resetn)
    (bus_req.rd && a == OFS_PIN_IN) |=> rdata == 8'($past(pin_in_value)))
    else $error("input read wrong");
  a_output_polarity: assert property (@(posedge core_clk) disable iff (!resetn)
    pad_out[0] == (level[0] ^ flip[0]))
    else $error("output polarity wrong");
endmodule : gpio_port

// *** test/gpio_pads.sv ***
// pad model: resolves each pad from port driver, external source and pull
`timescale 1ns/100ps
module gpio_pads (
  // clock
  input  wire logic       core_clk,
  // port side
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pull,
  // external source
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_lvl,
  output logic [7:0]      pad_in
);
  logic [7:0] tog = 8'h00;
  // floating pad without pull never holds a stable level
  always @(posedge core_clk) tog <= ~tog;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_lvl)
                | (~pad_oe & ~ext_en & (pad_pull | tog));
endmodule : gpio_pads

// *** test/tb.sv ***
// testbench: register access, pad and sensing checks of the gpio port
`timescale 1ns/100ps
module tb;
  import gpio_pkg::*;
  logic       core_clk  = 1'b0;
  logic       resetn    = 1'b0;
  bus_req_s   bus_req   = '0;
  logic [7:0] ext_en    = 8'h00;
  logic [7:0] ext_lvl   = 8'h00;
  logic [7:0] rdata, pad_in, pad_out, pad_oe, pad_pull, pad_in_en, irq_vector;
  logic       irq, wake;
  int         error_cnt = 0;
  int         n_checks  = 0;
  // sensing table for pin 3: mode, start level, flag expected
  sense_e     md [6]    = '{SENSE_NONE, SENSE_BOTH, SENSE_RISE, SENSE_FALL, SENSE_FALL, SENSE_LOW};
  logic [5:0] st        = 6'b110100;
  logic [5:0] ex        = 6'b110010;

  gpio_port dut (.core_clk(core_clk), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull(pad_pull),
    .pad_in_en(pad_in_en), .irq(irq), .irq_vector(irq_vector), .wake(wake));
  gpio_pads pads (.core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull(pad_pull), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(what, rdata, exp);
  endtask : rd

  task automatic finish_test;
    $display("checks %0d, errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #(100 * 3000);
    error_cnt++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    chk("pad_oe", pad_oe, 8'h00);
    chk("pad_in_en", pad_in_en, 8'hff);
    chk("irq_vector", irq_vector, 8'h00);
    wr(OFS_DIR_SET, 8'h0f);
    rd(OFS_DRIVE_EN, 8'h0f, "drive_en");
    wr(OFS_DIR_CLR, 8'h03);
    rd(OFS_DIR_CLR, 8'h0c, "drive_en");
    wr(OFS_DIR_FLIP, 8'hff);
    rd(OFS_DRIVE_EN, 8'hf3, "drive_en");
    chk("pad_oe", pad_oe, 8'hf3);
    wr(OFS_LVL_SET, 8'ha5);
    wr(OFS_LVL_CLR, 8'h05);
    rd(OFS_LEVEL, 8'ha0, "level");
    wr(OFS_LVL_FLIP, 8'h0f);
    wr(OFS_PIN_IN, 8'hf0);
    rd(OFS_LEVEL, 8'h5f, "level");
    ext_en <= 8'h0c;
    ext_lvl <= 8'h08;
    repeat (4) @(posedge core_clk);
    rd(OFS_PIN_IN, 8'h5b, "input");
    rd(OFS_ALIAS_IN, 8'h5b, "alias input");
    wr(OFS_ALIAS_DIR, 8'h00);
    rd(OFS_DRIVE_EN, 8'h00, "drive_en");
    rd(OFS_ALIAS_LVL, 8'h5f, "alias level");
    wr(OFS_PIN_CFG + 6'h1, 8'h88);
    rd(OFS_PIN_CFG + 6'h1, 8'h88, "config");
    chk("pad_pull", pad_pull, 8'h02);
    chk("pad_out", pad_out, 8'h5d);
    ext_en <= 8'hff;
    ext_lvl <= 8'h09;
    wr(OFS_PIN_CFG, {5'h00, SENSE_OFF});
    #1;
    chk("pad_in_en", pad_in_en, 8'hfe);
    repeat (4) @(posedge core_clk);
    rd(OFS_PIN_IN, 8'h08, "input");
    rd(6'h0a, 8'h00, "unmapped");
    foreach (md[i])
    begin
      ext_lvl[3] <= st[i];
      wr(OFS_PIN_CFG + 6'h3, {5'h00, md[i]});
      repeat (4) @(posedge core_clk);
      wr(OFS_FLAGS, 8'hff);
      ext_lvl[3] <= ~st[i];
      repeat (8) @(posedge core_clk);
      rd(OFS_FLAGS, {4'h0, ex[i], 3'h0}, "flags");
      chk("irq", {7'h00, irq}, {7'h00, ex[i]});
      wr(OFS_PIN_CFG + 6'h3, 8'h00);
      wr(OFS_ALIAS_FLAGS, 8'h08);
      rd(OFS_FLAGS, 8'h00, "flags");
    end
    wr(OFS_PIN_CFG + 6'h3, {5'h00, SENSE_RISE});
    repeat (4) @(posedge core_clk);
    wr(OFS_FLAGS, 8'hff);
    wr(OFS_PIN_CFG + 6'h3, {5'h10, SENSE_RISE});
    repeat (8) @(posedge core_clk);
    rd(OFS_FLAGS, 8'h08, "flags");
    finish_test();
  end
endmodule : tb
